// ==== logic/vws_video_serializer.sv ====
// Video word serializer: selectable input stage feeding a shift register
// Notes on behaviour
// [RL1] Power-up reset clears both FIFO pointers
// [RL2] Mode low 0, high 1 selects FIFO
// [RL3] Pointer reset keeps stored FIFO words
// [RL4] Low pulse on mode high resets pointers
// [RL5] Controller starts pointer reset with load high
// [RL6] Write edge captures word at write pointer
// [RL7] Four words held; fifth write overwrites
// [RL8] Simultaneous write and read both accepted
// [RL9] Empty FIFO read needs write-to-load setup
// [RL10] Gate low never inhibits reading
// [RL11] First clock after load edge loads word; the code loads it on the second clock
// [RL12] Words leave in first-in first-out order
// [RL13] Hold high suppresses shifting
// [RL14] Past sixteen clocks, serial input emerges
// [RL15] Both modes low: single-word edge register
// [RL16] Single-word write precedes read by setup
// [RL17] Single-word: read each word before rewriting
// [RL18] Mode low high: transparent latch bypass
// [RL19] Transparent loads live or held word
// [RL20] Gate high ignores load strobes
// [RL21] Freeze forces both outputs to level
// [RL22] Second output tapped at bit eight
// [RL23] Sixteen-bit register, serial in at top
`timescale 1ns/1ps
`default_nettype none
module vws_video_serializer #(
   parameter int WIDTH = vws_pkg::WORD_W,
   parameter int DEPTH = vws_pkg::FIFO_DEPTH
)(
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                ce,
   input  wire logic                mode_select_low,
   input  wire logic                mode_select_high,
   input  wire vws_pkg::vws_in_s    mem_in,
   input  wire vws_pkg::vws_shift_s shift_ctl,
   output logic                     serial_out,
   output logic                     mid_word_out,
   output vws_pkg::vws_mode_e       mode,
   output logic                     fifo_empty
);
   // Pointer arithmetic wraps on two bits, so only this geometry is served
   if (WIDTH != vws_pkg::WORD_W || DEPTH != vws_pkg::FIFO_DEPTH)
   begin : g_bad_geom
      $error("vws_video_serializer: width or depth not supported");
   end

   // Pointer width follows the package, so the wrap stays at four words
   localparam int PW = vws_pkg::PTR_W;

   // Mode decode, used for the output and the stage logic
   function automatic vws_pkg::vws_mode_e decode_mode(input logic lo,
                                                      input logic hi);
      if (lo)
         decode_mode = vws_pkg::VWS_MODE_TRANSP; // RL18
      else if (hi)
         decode_mode = vws_pkg::VWS_MODE_FIFO;   // RL2
      else
         decode_mode = vws_pkg::VWS_MODE_SINGLE; // RL15
   endfunction

   assign mode = decode_mode(mode_select_low, mode_select_high);

   // All strobes are sampled levels, so an edge is seen one clock after
   // the pin moves; this costs a cycle of latency but keeps the block
   // on a single clock with no second domain to cross
   // Edge detection state for strobes
   logic wr_q;              // Previous write strobe
   logic ld_q;              // Previous load strobe
   logic msh_q;             // Previous mode select high
   logic next_wr_q;
   logic next_ld_q;
   logic next_msh_q;
   logic wr_rise;           // Write strobe rising edge
   logic ld_rise;           // Load strobe rising edge
   logic ptr_clear;         // Pointer reset request

   // FIFO storage and pointers
   logic [WIDTH-1:0] mem [DEPTH];      // Stored words, never cleared
   logic [WIDTH-1:0] next_mem [DEPTH];
   logic [PW-1:0]    wptr;             // Write position
   logic [PW-1:0]    rptr;             // Read position
   logic [PW:0]      count;            // Unread words
   logic [PW-1:0]    next_wptr;
   logic [PW-1:0]    next_rptr;
   logic [PW:0]      next_count;

   // Single-word register and transparent latch
   logic [WIDTH-1:0] word_reg;         // Edge-captured word
   logic [WIDTH-1:0] next_word_reg;
   logic [WIDTH-1:0] latch_word;       // Word held once strobe goes high
   logic [WIDTH-1:0] next_latch_word;
   logic [WIDTH-1:0] age [DEPTH];      // Cycles since each word was written
   logic [WIDTH-1:0] next_age [DEPTH];

   // Pending load: edge seen, waits for the next pixel clock
   logic             load_pend;
   logic             next_load_pend;
   logic             do_load;          // Shift register loads this cycle
   logic [WIDTH-1:0] load_word;        // Word presented to shift register
   logic             pop;              // FIFO read this cycle
   logic             push;             // FIFO write this cycle

   assign wr_rise   = mem_in.write_strobe & ~wr_q;
   assign ld_rise   = mem_in.load_strobe & ~ld_q;
   // Falling mode-high in FIFO mode; caller starts it with load high  RL5
   assign ptr_clear = msh_q & ~mode_select_high & ~mode_select_low; // RL4

   // Strobe history
   // Mode-high history resets low, so a pin held low at release
   // cannot look like a falling edge and clear the pointers
   always_comb
   begin
      next_wr_q  = mem_in.write_strobe;
      next_ld_q  = mem_in.load_strobe;
      next_msh_q = mode_select_high;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_q  <= 1'b0;
         ld_q  <= 1'b0;
         msh_q <= 1'b0;
      end
      else if (ce)
      begin
         wr_q  <= next_wr_q;
         ld_q  <= next_ld_q;
         msh_q <= next_msh_q;
      end
   end

   // Load request: a load edge arms, next clock loads; gate high drops it
   // A gated edge is lost for good, it is not replayed when the gate drops
   always_comb
   begin
      next_load_pend = load_pend;
      do_load        = 1'b0;
      if (load_pend)
      begin
         do_load        = 1'b1; // RL11
         next_load_pend = 1'b0;
      end
      if (ld_rise && !mem_in.load_gate) // RL20 RL10
         next_load_pend = 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         load_pend <= 1'b0;
      else if (ce)
         load_pend <= next_load_pend;
   end

   // A word written too recently is not yet visible to an empty FIFO read
   // Age saturates, so a word left unread for long stays readable
   assign pop  = do_load && (mode == vws_pkg::VWS_MODE_FIFO)
                 && (count != vws_pkg::CNT_RESET)
                 && (int'(age[rptr]) >= vws_pkg::WR_TO_LOAD_CYC); // RL9
   assign push = wr_rise && (mode == vws_pkg::VWS_MODE_FIFO);

   // FIFO next state: write and read in one cycle both happen
   always_comb
   begin
      next_wptr  = wptr;
      next_rptr  = rptr;
      next_count = count;
      for (int i = 0; i < DEPTH; i++)
      begin
         next_mem[i] = mem[i];
         next_age[i] = (age[i] == '1) ? age[i] : age[i] + 1'b1;
      end
      if (push)
      begin
         next_mem[wptr] = mem_in.data;     // RL6
         next_age[wptr] = '0;
         next_wptr      = wptr + vws_pkg::PTR_ONE;
      end
      if (pop)
         next_rptr = rptr + vws_pkg::PTR_ONE; // RL12
      // Count tracks unread words; overflow overwrites oldest  RL7
      unique case ({push, pop})
         2'b10:
         begin
            if (count == vws_pkg::CNT_FULL)
               next_rptr = rptr + vws_pkg::PTR_ONE;
            else
               next_count = count + vws_pkg::CNT_ONE;
         end
         2'b01:   next_count = count - vws_pkg::CNT_ONE;
         default: next_count = count; // RL8
      endcase
      // Clear wins over a write in the same cycle; the controller keeps
      // writes away by starting the clear with the load strobe high
      if (ptr_clear)
      begin
         // Pointers only; stored words stay as they are  RL3
         next_wptr  = vws_pkg::PTR_RESET; // RL4
         next_rptr  = vws_pkg::PTR_RESET;
         next_count = vws_pkg::CNT_RESET;
      end
   end

   // Reset clears pointers only, whatever the mode
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wptr  <= vws_pkg::PTR_RESET; // RL1
         rptr  <= vws_pkg::PTR_RESET;
         count <= vws_pkg::CNT_RESET;
      end
      else if (ce)
      begin
         wptr  <= next_wptr;
         rptr  <= next_rptr;
         count <= next_count;
      end
   end

   // Word storage has no reset: a pointer reset leaves stale words
   // Skipping it saves a wide reset fan-out; an unwritten word reads
   // as unknown in simulation until it is first written
   always_ff @(posedge clk)
   begin
      if (ce)
         for (int i = 0; i < DEPTH; i++)
         begin
            mem[i] <= next_mem[i];
            age[i] <= next_age[i];
         end
   end

   // Single-word register and transparent latch capture
   // The edge register moves only on a write edge; the latch follows
   // the bus in every cycle in which the strobe is sampled low
   always_comb
   begin
      next_word_reg   = word_reg;
      next_latch_word = latch_word;
      if (wr_rise)
         next_word_reg = mem_in.data; // RL15
      if (!mem_in.write_strobe)
         next_latch_word = mem_in.data; // RL18
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         word_reg   <= vws_pkg::WORD_RESET;
         latch_word <= vws_pkg::WORD_RESET;
      end
      else if (ce)
      begin
         word_reg   <= next_word_reg;
         latch_word <= next_latch_word;
      end
   end

   // Word chosen for the load; empty or too-new FIFO gives the old word
   always_comb
   begin
      unique case (mode)
         vws_pkg::VWS_MODE_FIFO:
            load_word = pop ? mem[rptr]
                            : mem[rptr - vws_pkg::PTR_ONE]; // RL9
         vws_pkg::VWS_MODE_SINGLE:
            load_word = word_reg; // RL16 RL17
         vws_pkg::VWS_MODE_TRANSP:
            // Live data while strobe low, else the held word
            load_word = mem_in.write_strobe ? latch_word
                                            : mem_in.data; // RL19
         // Covers codes that the mode decode never produces
         default:
            load_word = word_reg;
      endcase
   end

   // Empty flag comes from registered state, so it never glitches
   assign fifo_empty = (count == vws_pkg::CNT_RESET);

   // Shift register and output taps
   vws_shifter #(
      .WIDTH (WIDTH),
      .TAP   (vws_pkg::MID_TAP)
   ) vws_shifter_inst (
      .clk          (clk),
      .rst          (rst),
      .ce           (ce),
      .load         (do_load),
      .load_word    (load_word),
      .ctl          (shift_ctl),
      .serial_out   (serial_out),
      .mid_word_out (mid_word_out)
   );
endmodule
`default_nettype wire

// ==== logic/vws_pkg.sv ====
// Package for the video word serializer: widths, modes, reset values, carriers
package vws_pkg;
   localparam int WORD_W = 16;                 // Word width
   localparam int FIFO_DEPTH = 4;              // FIFO depth in words
   localparam int MID_TAP = 8;                 // Bit tapped for mid_word_out
   localparam int PTR_W = 2;                   // FIFO pointer width
   localparam logic [PTR_W-1:0] PTR_RESET = 2'h0; // Pointer value after reset
   localparam logic [PTR_W-1:0] PTR_ONE = 2'h1;   // Pointer step
   localparam logic [PTR_W:0] CNT_RESET = 3'h0;   // Fill count after reset
   localparam logic [PTR_W:0] CNT_ONE = 3'h1;     // Fill count step
   localparam logic [PTR_W:0] CNT_FULL = 3'h4;    // Fill count when full
   localparam logic [15:0] WORD_RESET = 16'h0000; // Word value after reset
   localparam int WR_TO_LOAD_NS = 20;          // Write to load setup, ns
   localparam int CLK_NS = 20;                 // Clock period, ns
   // Least time rounds up, never below one cycle
   localparam int WR_TO_LOAD_CYC = (WR_TO_LOAD_NS + CLK_NS - 1) / CLK_NS < 1
      ? 1 : (WR_TO_LOAD_NS + CLK_NS - 1) / CLK_NS;

   // Input stage modes, one-hot
   typedef enum logic [2:0]
   {
      VWS_MODE_FIFO   = 3'b001,
      VWS_MODE_SINGLE = 3'b010,
      VWS_MODE_TRANSP = 3'b100
   } vws_mode_e;

   // Strobes and controls from the memory side
   typedef struct packed
   {
      logic        write_strobe;
      logic        load_strobe;
      logic        load_gate;
      logic [15:0] data;
   } vws_in_s;

   // Shift register controls from the pixel side
   typedef struct packed
   {
      logic serial_in;
      logic hold;
      logic output_freeze;
      logic freeze_level;
   } vws_shift_s;
endpackage

// ==== logic/vws_shifter.sv ====
// Shift register with parallel load, hold, freeze and two serial taps
`timescale 1ns/1ps
`default_nettype none
module vws_shifter #(
   parameter int WIDTH = vws_pkg::WORD_W,
   parameter int TAP   = vws_pkg::MID_TAP
)(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic              load,
   input  wire logic [WIDTH-1:0]  load_word,
   input  wire vws_pkg::vws_shift_s ctl,
   output logic                   serial_out,
   output logic                   mid_word_out
);
   // Tap must lie inside the word
   if (TAP >= WIDTH || TAP < 1)
   begin : g_bad_tap
      $error("vws_shifter: tap outside word");
   end

   logic [WIDTH-1:0] shreg;       // Shift register bits
   logic [WIDTH-1:0] next_shreg;  // Next shift register bits

   // Load wins; otherwise shift toward bit zero unless held
   always_comb
   begin
      next_shreg = shreg;
      if (load)
      begin
         next_shreg = load_word; // RL11
      end
      else if (!ctl.hold)
      begin
         // Serial input enters the top bit, so cascades keep going
         next_shreg = {ctl.serial_in, shreg[WIDTH-1:1]}; // RL23 RL14
      end
      // Hold leaves the word unchanged, output stays put  RL13
   end

   // Register only
   always_ff @(posedge clk)
   begin
      if (rst)
         shreg <= '0;
      else if (ce)
         shreg <= next_shreg;
   end

   // Freeze forces both taps while internal bits keep shifting
   assign serial_out   = ctl.output_freeze ? ctl.freeze_level : shreg[0]; // RL21
   assign mid_word_out = ctl.output_freeze ? ctl.freeze_level
                                           : shreg[TAP]; // RL22
endmodule
`default_nettype wire

// ==== bench/vws_video_serializer_assertions.sv ====
// Property checker for the video word serializer, bound to its top
`timescale 1ns/1ps
`default_nettype none
module vws_video_serializer_assertions (
   input wire logic                clk,
   input wire logic                rst,
   input wire logic                ce,
   input wire logic                mode_select_low,
   input wire logic                mode_select_high,
   input wire vws_pkg::vws_in_s    mem_in,
   input wire vws_pkg::vws_shift_s shift_ctl,
   input wire logic                serial_out,
   input wire logic                mid_word_out,
   input wire vws_pkg::vws_mode_e  mode,
   input wire logic                fifo_empty
);
   logic       ls_d; // Load strobe one cycle back
   logic       ws_d; // Write strobe one cycle back
   logic       pend; // Accepted load edge, shift reg loads next edge
   logic [3:0] run;  // Plain shift edges in a row, saturates at 8
   logic       fz;   // Output freeze
   assign fz = shift_ctl.output_freeze;
   // Helper state; a gated load must not break a run
   always_ff @(posedge clk)
   begin
      ls_d <= mem_in.load_strobe;
      ws_d <= mem_in.write_strobe;
      pend <= !rst && ce && mem_in.load_strobe && !ls_d
         && !mem_in.load_gate;
      if (rst || pend || fz || shift_ctl.hold || !ce)
         run <= 4'h0;
      else if (run != 4'h8)
         run <= run + 4'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   freeze_out_a:
      assert property (fz |-> serial_out == shift_ctl.freeze_level
         && mid_word_out == shift_ctl.freeze_level)
      else $error("freeze level not forced");
   mode_fifo_a:
      assert property (!mode_select_low && mode_select_high
         |-> mode == vws_pkg::VWS_MODE_FIFO)
      else $error("fifo mode not decoded");
   mode_single_a:
      assert property (!mode_select_low && !mode_select_high
         |-> mode == vws_pkg::VWS_MODE_SINGLE)
      else $error("single mode not decoded");
   mode_bypass_a:
      assert property (mode_select_low |-> mode == vws_pkg::VWS_MODE_TRANSP)
      else $error("transparent mode not decoded");
   hold_still_a:
      assert property (ce && shift_ctl.hold && !pend && !fz ##1 !fz
         |-> $stable(serial_out) && $stable(mid_word_out))
      else $error("output moved under hold");
   shift_run_a:
      assert property (run == 4'h8 && !fz
         |-> serial_out == $past(mid_word_out, 8))
      else $error("bit eight did not reach output");
   load_live_a:
      assert property (pend && mode_select_low && !mem_in.write_strobe
         && !fz |=> fz || serial_out == $past(mem_in.data[0])
         && mid_word_out == $past(mem_in.data[8]))
      else $error("live word not loaded");
   ptr_clear_a:
      assert property ($fell(mode_select_high) && !mode_select_low
         && !mem_in.write_strobe |=> fifo_empty)
      else $error("pointer clear missed");
   write_fill_a:
      assert property (mem_in.write_strobe && !ws_d && !mode_select_low
         && mode_select_high |=> !fifo_empty)
      else $error("write not stored");
   reset_empty_a:
      assert property (disable iff (1'b0) rst |=> fifo_empty)
      else $error("fifo not empty after reset");
endmodule
bind vws_video_serializer vws_video_serializer_assertions
   vws_video_serializer_assertions_inst (.clk(clk), .rst(rst), .ce(ce),
   .mode_select_low(mode_select_low), .mode_select_high(mode_select_high),
   .mem_in(mem_in), .shift_ctl(shift_ctl), .serial_out(serial_out),
   .mid_word_out(mid_word_out), .mode(mode), .fifo_empty(fifo_empty));
`default_nettype wire

// ==== bench/vws_mem_model.sv ====
// Memory and strobe source model driving the serializer inputs
`timescale 1ns/1ps
`default_nettype none
module vws_mem_model (
   input  wire logic            clk,
   output var vws_pkg::vws_in_s mem,
   output var logic             m_lo,
   output var logic             m_hi
);
   // Idle: strobes low, gate open, fifo mode selected
   initial
   begin
      mem = '0;
      m_lo = 1'b0;
      m_hi = 1'b1;
   end
   // Levels change at the falling edge only
   task automatic set(input logic ws, input logic [15:0] d);
      @(negedge clk);
      mem.write_strobe = ws;
      mem.data = d;
   endtask
   // One write; the bus then shows the inverse, never a stale word
   task automatic wr(input logic [15:0] d);
      set(1'b1, d);
      set(1'b0, ~d);
   endtask
   // One load strobe pulse
   task automatic ld();
      @(negedge clk);
      mem.load_strobe = 1'b1;
      @(negedge clk);
      mem.load_strobe = 1'b0;
   endtask
   task automatic gate(input logic g);
      @(negedge clk);
      mem.load_gate = g;
   endtask
   task automatic set_mode(input logic lo, input logic hi);
      @(negedge clk);
      m_lo = lo;
      m_hi = hi;
   endtask
   // Pointer clear starts only while the load strobe is high
   task automatic clr();
      @(negedge clk);
      mem.load_strobe = 1'b1;
      @(negedge clk);
      m_hi = 1'b0;
      @(negedge clk);
      m_hi = 1'b1;
      @(negedge clk);
      mem.load_strobe = 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== bench/vws_video_serializer_tb.sv ====
// Self-checking bench for the video word serializer
`timescale 1ns/1ps
`default_nettype none
module vws_video_serializer_tb;
   logic                clk;
   logic                rst;
   logic                ce;   // Clock enable
   vws_pkg::vws_in_s    mem;  // From the model
   vws_pkg::vws_shift_s sc;   // Shift controls
   logic                m_lo;
   logic                m_hi;
   logic                so;
   logic                mo;
   logic                emp;
   vws_pkg::vws_mode_e  mode;
   int                  n_fail;
   int                  total_checks;
   logic [15:0]         w [5];
   vws_video_serializer vws_video_serializer_inst (.clk(clk), .rst(rst),
      .ce(ce), .mode_select_low(m_lo), .mode_select_high(m_hi),
      .mem_in(mem), .shift_ctl(sc), .serial_out(so), .mid_word_out(mo),
      .mode(mode), .fifo_empty(emp));
   vws_mem_model vws_mem_model_inst (.clk(clk), .mem(mem), .m_lo(m_lo),
      .m_hi(m_hi));
   task automatic chk(input string nm, input logic e, input logic s);
      total_checks++;
      if (s !== e)
      begin
         n_fail++;
         $display("unexpected %s exp %b got %b", nm, e, s);
      end
   endtask
   // Load a word, watch all bits leave, optionally hold at bit hp
   task automatic rd(input logic [15:0] x, input int hp);
      vws_mem_model_inst.ld();
      @(negedge clk);
      chk("mid", x[8], mo);
      for (int i = 0; i < 16; i++)
      begin
         chk("serial", x[i], so);
         if (i == hp)
         begin
            sc.hold = 1'b1;
            repeat (3)
            begin
               @(negedge clk);
               chk("held", x[i], so);
            end
            sc.hold = 1'b0;
         end
         @(negedge clk);
      end
      chk("tail", 1'b1, so);
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      #200000;
      n_fail++;
      print_verdict();
   end
   initial
   begin
      w = '{16'h8001, 16'h1234, 16'hBEEF, 16'h00FF, 16'hC35A};
      n_fail = 0;
      total_checks = 0;
      rst = 1'b1;
      ce = 1'b1;
      sc = '{1'b1, 1'b0, 1'b0, 1'b0};
      repeat (4) @(negedge clk);
      rst = 1'b0;
      chk("empty", 1'b1, emp);
      for (int i = 0; i < 4; i++) vws_mem_model_inst.wr(w[i]);
      for (int i = 0; i < 4; i++) rd(w[i], 99);
      chk("empty", 1'b1, emp);
      // Fifth write drops the oldest word
      for (int i = 0; i < 5; i++) vws_mem_model_inst.wr(w[i]);
      for (int i = 1; i < 5; i++) rd(w[i], i);
      rd(w[4], 99);
      // Gated strobe is ignored, loads resume once the gate drops
      vws_mem_model_inst.wr(16'h0000);
      vws_mem_model_inst.gate(1'b1);
      vws_mem_model_inst.ld();
      repeat (3) @(negedge clk);
      chk("gated", 1'b1, so);
      vws_mem_model_inst.gate(1'b0);
      rd(16'h0000, 99);
      // Freeze forces outputs while bits keep moving inside
      vws_mem_model_inst.wr(16'h0004);
      vws_mem_model_inst.ld();
      @(negedge clk);
      sc.output_freeze = 1'b1;
      sc.freeze_level = 1'b1;
      @(negedge clk);
      chk("frz_mid", 1'b1, mo);
      sc.freeze_level = 1'b0;
      @(negedge clk);
      chk("frz_out", 1'b0, so);
      sc.output_freeze = 1'b0;
      #1 chk("unfrz", 1'b1, so);
      vws_mem_model_inst.wr(w[0]);
      vws_mem_model_inst.wr(w[1]);
      vws_mem_model_inst.clr();
      chk("cleared", 1'b1, emp);
      // Empty read after the clear still finds the stale word
      rd(w[0], 99);
      vws_mem_model_inst.wr(w[2]);
      rd(w[2], 99);
      // Single-word register keeps only the latest write
      vws_mem_model_inst.set_mode(1'b0, 1'b0);
      vws_mem_model_inst.wr(w[3]);
      rd(w[3], 99);
      vws_mem_model_inst.wr(w[0]);
      vws_mem_model_inst.wr(w[1]);
      rd(w[1], 99);
      // Transparent: live word, then a held word loaded twice
      vws_mem_model_inst.set_mode(1'b1, 1'b0);
      vws_mem_model_inst.set(1'b0, 16'hA5C3);
      rd(16'hA5C3, 99);
      // The latch closes on the word it last saw with the strobe low
      vws_mem_model_inst.set(1'b0, 16'h3C5A);
      vws_mem_model_inst.set(1'b1, 16'h3C5A);
      vws_mem_model_inst.set(1'b1, 16'hFFFF);
      rd(16'h3C5A, 99);
      rd(16'h3C5A, 99);
      // Clock enable low freezes the shift register
      vws_mem_model_inst.ld();
      @(negedge clk);
      ce = 1'b0;
      repeat (3) @(negedge clk);
      chk("ce_hold", 1'b0, so);
      ce = 1'b1;
      @(negedge clk);
      chk("ce_run", 1'b1, so);
      print_verdict();
   end
endmodule
`default_nettype wire
